// File: rtl/tcc_top.sv
// Two-channel timer capture/compare core with AXI4-Lite register access
// How it works
// RL1: Interrupt enable bit gates channel event requests
// RL2: Buffered select bit exists only in channel 0
// RL3: Buffered mode locks channel 1 control, frees pin
// RL4: Nonzero edge field: low mode picks capture/compare
// RL5: Edge field zero: low mode sets preset level
// RL6: Edge field zero disconnects the channel pin
// RL7: Capture edge: rising, falling or either
// RL8: Compare action: toggle, clear or set pin
// RL9: Software stops and resets counter before mode change
// RL10: Pin stable two clocks before enabling capture
// RL11: Toggle-on-overflow flips compare pin each overflow
// RL12: Overflow toggle beats simultaneous compare action
// RL13: Full-duty bit forces 100% from next cycle; code ignores it while the toggle bit is set
// RL14: High byte read blocks captures until low read
// RL15: High byte write blocks compares until low write
// RL16: Value registers hold capture or compare, no reset
// RL17: Reset clears enable, mode, edge and toggle bits
// RL18: Flag set by event; writing one does nothing
// RL19: Capture latches the counter into value
// RL20: Last written channel drives buffered output at overflow
// RL21: Channels share counter and one-cycle overflow pulse
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_top import tcc_pkg::*; #(
  parameter int CW = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CW-1:0] counter_value,
  input wire logic counter_overflow,
  input wire logic [1:0] channel_pin_in,
  output logic [1:0] channel_pin_out,
  output logic [1:0] channel_pin_oe_n,
  output logic [1:0] channel_irq
);
  if (CW != 16) begin : g_chk
    $error("tcc_top: counter width must be 16");
  end

  tcc_reg_if rb ();
  tcc_ctl_t ctl0;
  tcc_ctl_t ctl1;
  logic buf_d;
  logic owner;
  logic last_wr;
  logic full0;
  logic full1;
  logic flag0;
  logic flag1;
  logic hit0;
  logic hit1;
  logic [CW-1:0] value0;
  logic [CW-1:0] value1;

  tcc_axil u_bus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb)
  );

  // Address decode
  wire logic wr_ctl0 = rb.wr && rb.waddr == `TCC_OFF_CTL0;
  wire logic wr_ctl1 = rb.wr && rb.waddr == `TCC_OFF_CTL1;
  wire logic wr_hi0 = rb.wr && rb.waddr == `TCC_OFF_VAL0H;
  wire logic wr_lo0 = rb.wr && rb.waddr == `TCC_OFF_VAL0L;
  wire logic wr_hi1 = rb.wr && rb.waddr == `TCC_OFF_VAL1H;
  wire logic wr_lo1 = rb.wr && rb.waddr == `TCC_OFF_VAL1L;
  wire logic rd_ctl0 = rb.rd && rb.raddr == `TCC_OFF_CTL0;
  wire logic rd_ctl1 = rb.rd && rb.raddr == `TCC_OFF_CTL1;
  wire logic rd_hi0 = rb.rd && rb.raddr == `TCC_OFF_VAL0H;
  wire logic rd_lo0 = rb.rd && rb.raddr == `TCC_OFF_VAL0L;
  wire logic rd_hi1 = rb.rd && rb.raddr == `TCC_OFF_VAL1H;
  wire logic rd_lo1 = rb.rd && rb.raddr == `TCC_OFF_VAL1L;
  wire logic wr_val0 = wr_hi0 || wr_lo0;
  wire logic wr_val1 = wr_hi1 || wr_lo1;
  wire logic [7:0] wdata = rb.wdata;
  wire tcc_ctl_t wr_ctl_v = tcc_ctl_t'(wdata[`TCC_B_IE:0]);
  wire logic clr0 = wr_ctl0 && !wdata[`TCC_B_FLAG];
  wire logic clr1 = wr_ctl1 && !wdata[`TCC_B_FLAG];

  function automatic logic is_reg(input logic [7:0] a);
    return a inside {`TCC_OFF_CTL0, `TCC_OFF_CTL1, `TCC_OFF_VAL0H,
                     `TCC_OFF_VAL0L, `TCC_OFF_VAL1H, `TCC_OFF_VAL1L};
  endfunction : is_reg

  assign rb.werr = !is_reg(rb.waddr);
  assign rb.rerr = !is_reg(rb.raddr);

  // Mode decode
  wire logic buf_on = ctl0.msb; // see RL2
  // Channel 1 control reads and acts as cleared while linked
  wire tcc_ctl_t c1 = buf_on ? tcc_ctl_t'(`TCC_CTL_RST) : ctl1; // see RL3
  wire logic cap_en0 = ctl0.els != TCC_ELS_OFF && !ctl0.msb && !ctl0.msa; // see RL4
  wire logic cmp_en0 = ctl0.els != TCC_ELS_OFF && (ctl0.msb || ctl0.msa); // see RL4 RL2
  wire logic cap_en1 = c1.els != TCC_ELS_OFF && !c1.msa; // see RL4
  wire logic cmp_en1 = c1.els != TCC_ELS_OFF && c1.msa; // see RL4
  wire logic cmp_mode0 = ctl0.msb || ctl0.msa;
  // Channel 1 still matches while linked; its value is the second buffer
  wire logic cmp_mode1 = buf_on || c1.msa;
  wire logic sel_hit = owner ? hit1 : hit0; // see RL20
  wire logic cmp_hit0 = cmp_en0 && (buf_on ? sel_hit : hit0);
  wire logic cmp_hit1 = cmp_en1 && hit1;

  tcc_chan #(.W(CW)) u_ch0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cnt(counter_value),
    .pin_in(channel_pin_in[0]),
    .cap_en(cap_en0),
    .cap_edge(ctl0.els),
    .cmp_mode(cmp_mode0),
    .ext_set(cmp_hit0),
    .wr_hi(wr_hi0),
    .wr_lo(wr_lo0),
    .rd_hi(rd_hi0),
    .rd_lo(rd_lo0),
    .rd_ctl(rd_ctl0),
    .clr_flag(clr0),
    .wdata(wdata),
    .value(value0),
    .flag(flag0),
    .hit(hit0)
  );

  tcc_chan #(.W(CW)) u_ch1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cnt(counter_value),
    .pin_in(channel_pin_in[1]),
    .cap_en(cap_en1),
    .cap_edge(c1.els),
    .cmp_mode(cmp_mode1),
    .ext_set(cmp_hit1),
    .wr_hi(wr_hi1),
    .wr_lo(wr_lo1),
    .rd_hi(rd_hi1),
    .rd_lo(rd_lo1),
    .rd_ctl(rd_ctl1 && !buf_on),
    .clr_flag(clr1 && !buf_on),
    .wdata(wdata),
    .value(value1),
    .flag(flag1),
    .hit(hit1)
  );

  // Read mux
  wire logic [7:0] ctl0_view = {flag0, ctl0};
  wire logic [7:0] ctl1_view = {flag1 && !buf_on, c1};
  assign rb.rdata = rb.raddr == `TCC_OFF_CTL0 ? ctl0_view :
                    rb.raddr == `TCC_OFF_CTL1 ? ctl1_view :
                    rb.raddr == `TCC_OFF_VAL0H ? value0[CW-1:8] :
                    rb.raddr == `TCC_OFF_VAL0L ? value0[7:0] :
                    rb.raddr == `TCC_OFF_VAL1H ? value1[CW-1:8] :
                    rb.raddr == `TCC_OFF_VAL1L ? value1[7:0] : 8'h00;

  // Pin level for the next cycle; priority order matters
  function automatic logic pin_next(input tcc_ctl_t c, input logic en, input logic hit,
                                    input logic ovf, input logic full, input logic q);
    logic r;
    r = q;
    if (c.els == TCC_ELS_OFF) begin
      r = !c.msa; // see RL5
    end else if (!en) begin
      r = q;
    end else if (c.tov && ovf) begin
      r = !q; // see RL11 RL12
    end else if (full && !c.tov) begin
      r = c.els != TCC_ELS_AB; // see RL13
    end else if (hit) begin
      case (c.els)
        TCC_ELS_A: r = !q; // see RL8
        TCC_ELS_B: r = 1'b0; // see RL8
        TCC_ELS_AB: r = 1'b1; // see RL8
        default: r = q;
      endcase
    end
    return r;
  endfunction : pin_next

  wire logic next_pin0 = pin_next(ctl0, cmp_en0, cmp_hit0, counter_overflow, full0, channel_pin_out[0]);
  wire logic next_pin1 = pin_next(c1, cmp_en1, cmp_hit1, counter_overflow, full1, channel_pin_out[1]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl0 <= tcc_ctl_t'(`TCC_CTL_RST); // see RL17
      ctl1 <= tcc_ctl_t'(`TCC_CTL_RST); // see RL17
    end else begin
      if (wr_ctl0) begin
        ctl0 <= wr_ctl_v;
      end
      if (wr_ctl1 && !buf_on) begin
        ctl1 <= wr_ctl_v;
        ctl1.msb <= 1'b0; // see RL2 RL3
      end
    end
  end

  // Buffer ownership flips only at overflow or on entry to buffered mode (back to channel 0), so a running period is never split
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_d <= 1'b0;
      owner <= 1'b0;
      last_wr <= 1'b0;
    end else begin
      buf_d <= buf_on;
      if (buf_on && !buf_d) begin
        owner <= 1'b0;
        last_wr <= 1'b0;
      end else begin
        if (wr_val1) begin
          last_wr <= 1'b1;
        end else if (wr_val0) begin
          last_wr <= 1'b0;
        end
        if (buf_on && counter_overflow) begin
          owner <= last_wr; // see RL20 RL21
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      full0 <= 1'b0;
      full1 <= 1'b0;
      channel_pin_out <= 2'h3;
      channel_pin_oe_n <= 2'h3;
      channel_irq <= 2'h0;
    end else begin
      full0 <= counter_overflow ? ctl0.max : full0; // see RL13
      full1 <= counter_overflow ? c1.max : full1; // see RL13
      channel_pin_out <= {next_pin1, next_pin0};
      channel_pin_oe_n <= {!cmp_en1, !cmp_en0}; // see RL6 RL3
      channel_irq <= {flag1 && c1.ie, flag0 && ctl0.ie}; // see RL1
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_full0;
    cmp_en0 && full0 && !ctl0.tov && ctl0.els == TCC_ELS_B;
  endsequence
  sequence s_take1;
    buf_on && buf_d && last_wr && counter_overflow;
  endsequence

  property p_irq_pass;
    flag0 && ctl0.ie |=> channel_irq[0];
  endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("enabled flag gave no request"); // see RL1
  property p_irq_block;
    !c1.ie |=> !channel_irq[1];
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("disabled channel requested"); // see RL1
  property p_msb1;
    wr_ctl1 |=> !ctl1.msb;
  endproperty
  a_msb1: assert property (p_msb1) else $error("channel 1 took buffered select"); // see RL2
  property p_ch1_lock;
    buf_on && wr_ctl1 |=> $stable(ctl1);
  endproperty
  a_ch1_lock: assert property (p_ch1_lock) else $error("locked control changed"); // see RL3
  property p_ch1_port;
    buf_on |=> channel_pin_oe_n[1];
  endproperty
  a_ch1_port: assert property (p_ch1_port) else $error("channel 1 pin driven while linked"); // see RL3
  property p_cap_in;
    cap_en0 ##1 cap_en0 |-> channel_pin_oe_n[0];
  endproperty
  a_cap_in: assert property (p_cap_in) else $error("capture pin driven"); // see RL4
  property p_preset;
    ctl0.els == TCC_ELS_OFF |=> channel_pin_out[0] == !$past(ctl0.msa) && channel_pin_oe_n[0];
  endproperty
  a_preset: assert property (p_preset) else $error("preset level wrong"); // see RL5 RL6
  property p_clear;
    cmp_en0 && ctl0.els == TCC_ELS_B && cmp_hit0 && !ctl0.tov && !full0 |=> !channel_pin_out[0];
  endproperty
  a_clear: assert property (p_clear) else $error("clear on compare missed"); // see RL8
  property p_tov;
    cmp_en0 && ctl0.tov && counter_overflow |=> channel_pin_out[0] != $past(channel_pin_out[0]);
  endproperty
  a_tov: assert property (p_tov) else $error("overflow toggle missed"); // see RL11 RL12
  property p_full;
    s_full0 |=> channel_pin_out[0];
  endproperty
  a_full: assert property (p_full) else $error("full duty not held"); // see RL13
  property p_full_wait;
    !full0 && !counter_overflow |=> !full0;
  endproperty
  a_full_wait: assert property (p_full_wait) else $error("full duty before cycle start"); // see RL13
  property p_owner;
    s_take1 |=> owner;
  endproperty
  a_owner: assert property (p_owner) else $error("buffer owner not switched"); // see RL20
  property p_oe_cmp;
    cmp_en0 |=> !channel_pin_oe_n[0];
  endproperty
  a_oe_cmp: assert property (p_oe_cmp) else $error("compare pin not driven"); // see RL4 RL6
  property p_irq1_pass;
    flag1 && c1.ie |=> channel_irq[1];
  endproperty
  a_irq1_pass: assert property (p_irq1_pass) else $error("channel 1 flag gave no request"); // see RL1
  property p_buf_irq;
    buf_on |=> !channel_irq[1];
  endproperty
  a_buf_irq: assert property (p_buf_irq) else $error("linked channel 1 requested"); // see RL3
endmodule : tcc_top

// File: rtl/tcc_params.svh
// Register offsets, field positions, reset values and bus answers of the timer channel block
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_OFF_CTL0 8'h00
`define TCC_OFF_CTL1 8'h04
`define TCC_OFF_VAL0H 8'h08
`define TCC_OFF_VAL0L 8'h0C
`define TCC_OFF_VAL1H 8'h10
`define TCC_OFF_VAL1L 8'h14
`define TCC_B_FLAG 7
`define TCC_B_IE 6
`define TCC_CTL_RST 7'h00
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2
`define TCC_RDATA_PAD 24'h000000
`endif

// File: rtl/tcc_pkg.sv
// Types shared by the timer channel capture/compare block
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_ELS_OFF = 2'b00,
    TCC_ELS_A = 2'b01,
    TCC_ELS_B = 2'b10,
    TCC_ELS_AB = 2'b11
  } tcc_els_t;
  typedef struct packed {
    logic ie;
    logic msb;
    logic msa;
    tcc_els_t els;
    logic tov;
    logic max;
  } tcc_ctl_t;
endpackage : tcc_pkg

// File: rtl/tcc_reg_if.sv
// Register strobe carrier between the bus slave and the timer core
`timescale 1ns/1ps
interface tcc_reg_if;
  logic wr;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic werr;
  logic rd;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic rerr;
  modport slave (output wr, waddr, wdata, rd, raddr, input werr, rdata, rerr);
  modport core (input wr, waddr, wdata, rd, raddr, output werr, rdata, rerr);
endinterface : tcc_reg_if

// File: rtl/tcc_axil.sv
// AXI4-Lite slave turning bus transfers into one-cycle register strobes
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_axil (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  tcc_reg_if.slave rb
);
  logic wen;
  logic rd_pend;
  // Both halves held and no answer out yet
  wire logic go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rb.wr = go && wen;
  assign rb.rd = rd_pend;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TCC_RESP_OKAY;
      rd_pend <= 1'b0;
      wen <= 1'b0;
      rb.waddr <= 8'h00;
      rb.wdata <= 8'h00;
      rb.raddr <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        rb.waddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        rb.wdata <= s_axi_wdata[7:0];
        wen <= s_axi_wstrb[0];
      end
      if (go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= rb.werr ? `TCC_RESP_SLVERR : `TCC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rb.raddr <= s_axi_araddr;
        rd_pend <= 1'b1;
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {`TCC_RDATA_PAD, rb.rdata};
        s_axi_rresp <= rb.rerr ? `TCC_RESP_SLVERR : `TCC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : tcc_axil

// File: rtl/tcc_chan.sv
// One capture/compare channel: edge capture, match, event flag, value bytes
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_chan import tcc_pkg::*; #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] cnt,
  input wire logic pin_in,
  input wire logic cap_en,
  input wire tcc_els_t cap_edge,
  input wire logic cmp_mode,
  input wire logic ext_set,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic rd_hi,
  input wire logic rd_lo,
  input wire logic rd_ctl,
  input wire logic clr_flag,
  input wire logic [7:0] wdata,
  output logic [W-1:0] value,
  output logic flag,
  output logic hit
);
  if (W != 16) begin : g_chk
    $error("tcc_chan: value width must be 16");
  end
  logic pin_d;
  logic cap_blk;
  logic cmp_blk;
  logic armed;
  logic [W-1:0] cnt_d;

  // Pin is assumed settled before capture is enabled; see RL10
  wire logic rise = pin_in && !pin_d;
  wire logic fall = !pin_in && pin_d;
  wire logic edge_ok = (cap_edge == TCC_ELS_A && rise) || (cap_edge == TCC_ELS_B && fall) ||
                       (cap_edge == TCC_ELS_AB && (rise || fall)); // see RL7
  wire logic cap_ev = cap_en && !cap_blk && edge_ok; // see RL14
  // Match only when the counter moves, so a stopped counter gives one event
  assign hit = cmp_mode && !cmp_blk && cnt != cnt_d && cnt == value; // see RL15 RL21
  wire logic set_ev = cap_ev || ext_set;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_d <= 1'b0;
      cnt_d <= '0;
      cap_blk <= 1'b0;
      cmp_blk <= 1'b0;
      armed <= 1'b0;
      flag <= 1'b0;
    end else begin
      pin_d <= pin_in;
      cnt_d <= cnt;
      cap_blk <= cap_en && (rd_hi || (cap_blk && !rd_lo)); // see RL14
      cmp_blk <= cmp_mode && (wr_hi || (cmp_blk && !wr_lo)); // see RL15
      // A new event disarms the pending clear so it cannot be lost
      armed <= set_ev ? 1'b0 : (rd_ctl ? flag : (armed && !clr_flag));
      flag <= set_ev || (flag && !(clr_flag && armed)); // see RL18
    end
  end

  // Left without reset on purpose; contents are unknown until loaded
  always_ff @(posedge clk_sys) begin
    if (cap_ev) begin
      value <= cnt; // see RL19 RL16
    end else if (wr_hi) begin
      value[W-1:8] <= wdata;
    end else if (wr_lo) begin
      value[7:0] <= wdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_cap_latch;
    cap_ev |=> value == $past(cnt);
  endproperty
  a_cap_latch: assert property (p_cap_latch) else $error("capture did not latch counter"); // see RL19
  property p_cap_block;
    cap_en && rd_hi ##1 cap_en && !rd_lo |-> !cap_ev;
  endproperty
  a_cap_block: assert property (p_cap_block) else $error("capture after high byte read"); // see RL14
  property p_cmp_block;
    cmp_mode && wr_hi ##1 cmp_mode && !wr_lo |-> !hit;
  endproperty
  a_cmp_block: assert property (p_cmp_block) else $error("compare after high byte write"); // see RL15
  property p_flag_set;
    set_ev |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event lost"); // see RL18
  property p_flag_idle;
    !flag && !set_ev |=> !flag;
  endproperty
  a_flag_idle: assert property (p_flag_idle) else $error("flag rose without event"); // see RL18
endmodule : tcc_chan

// File: tb/tcc_cnt_model.sv
// Shared counter and overflow source seen by the channels
`timescale 1ns/1ps
module tcc_cnt_model #(
  parameter logic [15:0] MOD = 16'h003F
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic counter_halt,
  output logic [15:0] counter_value,
  output logic counter_overflow
);
  // Short modulo keeps compare periods to 64 cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= 16'h0000;
      counter_overflow <= 1'b0;
    end else if (counter_halt) begin
      counter_overflow <= 1'b0;
    end else begin
      counter_overflow <= (counter_value == MOD);
      counter_value <= (counter_value == MOD) ? 16'h0000 : counter_value + 16'h0001;
    end
  end
endmodule : tcc_cnt_model

// File: tb/tb_top.sv
// Register-level tests of the timer channel block
`timescale 1ns/1ps
`include "tcc_params.svh"
module tb_top;
  logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, halt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [1:0] pins;
  wire awready, wready, bvalid, arready, rvalid, ovf;
  wire [1:0] bresp, rresp, pout, poe_n, irq;
  wire [31:0] rdata;
  wire [15:0] cnt;
  int n_errors, compares;
  logic [15:0] cap;
  logic [1:0] r;
  logic [31:0] d;
  logic [7:0] act [3] = '{8'h5C, 8'h58, 8'h54};
  logic lvl [3] = '{1'b1, 1'b0, 1'b1};

  tcc_cnt_model u_tcc_cnt_model (.clk_sys(clk_sys), .rst_n(rst_n), .counter_halt(halt),
    .counter_value(cnt), .counter_overflow(ovf));
  tcc_top #(.CW(16)) u_tcc_top (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .counter_value(cnt), .counter_overflow(ovf), .channel_pin_in(pins), .channel_pin_out(pout),
    .channel_pin_oe_n(poe_n), .channel_irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv) begin
      n_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle limit here; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [1:0] resp;
    axw(a, v, resp);
    chk({30'h0, resp}, {30'h0, `TCC_RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] expv);
    logic [31:0] v;
    logic [1:0] resp;
    axr(a, v, resp);
    chk(v, {24'h000000, expv});
  endtask : rd

  task automatic wait_cnt(input logic [15:0] v);
    do begin
      @(posedge clk_sys);
    end while (cnt != v);
  endtask : wait_cnt

  task close_out;
    $display("counts errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    pins = 2'b00;
    halt = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`TCC_OFF_CTL0, 8'h00);
    rd(`TCC_OFF_CTL1, 8'h00);
    chk({30'h0, poe_n}, 32'h3);
    chk({30'h0, pout}, 32'h3);
    halt <= 1'b1;
    wr(`TCC_OFF_CTL0, 8'h10);
    @(posedge clk_sys);
    chk({31'h0, pout[0]}, 32'h0);
    $display("test reset done");
    axw(8'h18, 8'hFF, r);
    chk({30'h0, r}, {30'h0, `TCC_RESP_SLVERR});
    axr(8'h18, d, r);
    chk({30'h0, r}, {30'h0, `TCC_RESP_SLVERR});
    chk(d, 32'h00000000);
    $display("test unmapped done");
    // Frozen counter makes the captured value predictable
    wr(`TCC_OFF_CTL0, 8'h04);
    repeat (3) @(posedge clk_sys);
    cap = cnt;
    pins[0] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(`TCC_OFF_CTL0, 8'h84);
    chk({31'h0, irq[0]}, 32'h0);
    wr(`TCC_OFF_CTL0, 8'h04);
    rd(`TCC_OFF_VAL0H, cap[15:8]);
    pins[0] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    pins[0] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(`TCC_OFF_CTL0, 8'h04);
    rd(`TCC_OFF_VAL0L, cap[7:0]);
    pins[0] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(`TCC_OFF_CTL0, 8'h04);
    $display("test capture done");
    wr(`TCC_OFF_VAL1H, 8'h00);
    wr(`TCC_OFF_VAL1L, 8'h10);
    halt <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(`TCC_OFF_CTL1, act[i]);
      wait_cnt(16'h0008);
      wait_cnt(16'h0020);
      chk({31'h0, pout[1]}, {31'h0, lvl[i]});
      chk({31'h0, poe_n[1]}, 32'h0);
    end
    rd(`TCC_OFF_CTL1, 8'hD4);
    chk({31'h0, irq[1]}, 32'h1);
    $display("test compare done");
    wr(`TCC_OFF_CTL0, 8'h2C);
    rd(`TCC_OFF_CTL1, 8'h00);
    wr(`TCC_OFF_CTL1, 8'h5C);
    rd(`TCC_OFF_CTL1, 8'h00);
    chk({31'h0, poe_n[1]}, 32'h1);
    wr(`TCC_OFF_VAL0H, 8'h00);
    wr(`TCC_OFF_VAL0L, 8'h10);
    wr(`TCC_OFF_CTL0, 8'h6A);
    wait_cnt(16'h0008);
    wait_cnt(16'h0020);
    chk({31'h0, pout[0]}, 32'h0);
    chk({31'h0, poe_n[0]}, 32'h0);
    chk({31'h0, irq[0]}, 32'h1);
    wr(`TCC_OFF_VAL1H, 8'h00);
    wr(`TCC_OFF_VAL1L, 8'h30);
    wait_cnt(16'h0008);
    wait_cnt(16'h0020);
    chk({31'h0, pout[0]}, 32'h1);
    wr(`TCC_OFF_CTL0, 8'h29);
    wait_cnt(16'h0000);
    wait_cnt(16'h0038);
    chk({31'h0, pout[0]}, 32'h1);
    $display("test buffered done");
    close_out();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule : tb_top
